// File: verilog/tcsc_pkg.sv
// constants for the timer clock source control block
package tcsc_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_COUNT  = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MASK   = 8'h0C;
    localparam logic [7:0] ADDR_GATE   = 8'h10;
    // control field positions
    localparam int CS_LSB   = 6;
    localparam int PS_LSB   = 4;
    localparam int OSC_BIT  = 3;
    localparam int SYNC_BIT = 2;
    localparam int RUN_BIT  = 0;
    // writable bits of control (bit 1 unimplemented)
    localparam logic [7:0] CTRL_WMASK = 8'hFD;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
    // clock source encodings
    localparam logic [1:0] CS_INSTR = 2'h0;
    localparam logic [1:0] CS_SYS   = 2'h1;
    localparam logic [1:0] CS_EXT   = 2'h2;
    // instruction clock is system clock divided by four
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tcsc_pkg

// File: verilog/tcsc_prescale_if.sv
// interface between control block and prescaler
`timescale 1ns/1ps
interface tcsc_prescale_if;
    logic       tick_in;
    logic       clear;
    logic [1:0] ratio;
    logic       tick_out;
    modport ctrl (output tick_in, output clear, output ratio,
                  input tick_out);
    modport scaler (input tick_in, input clear, input ratio,
                    output tick_out);
endinterface : tcsc_prescale_if

// File: verilog/tcsc_prescaler.sv
// input prescaler dividing timer ticks by 1, 2, 4 or 8
`timescale 1ns/1ps
module tcsc_prescaler
(
    // clock and reset
    input  wire logic     clk_sys,
    input  wire logic     rst,
    // prescale link
    tcsc_prescale_if.scaler ps
);
    typedef struct packed {
        logic [2:0] count;
    } tcsc_ps_state_t;

    tcsc_ps_state_t state;
    tcsc_ps_state_t next_state;
    logic [2:0]     last;

    // terminal count per ratio
    always_comb
    begin
        case (ps.ratio)
            2'h0:    last = 3'h0;
            2'h1:    last = 3'h1;
            2'h2:    last = 3'h3;
            default: last = 3'h7;
        endcase
    end

    // pass every n-th tick
    always_comb
    begin
        next_state = state;
        if (ps.clear)
        begin
            next_state.count = 3'h0;
        end
        else if (ps.tick_in)
        begin
            if (state.count >= last)
            begin
                next_state.count = 3'h0;
            end
            else
            begin
                next_state.count = state.count + 3'h1;
            end
        end
    end

    assign ps.tick_out = ps.tick_in && !ps.clear && (state.count >= last);

    // state register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end
endmodule : tcsc_prescaler

// File: verilog/tcsc_top.sv
// timer clock source control with 16-bit counter and axi4-lite slave
// Function
// - source select 00 counts the instruction clock, system clock / 4.
// - the prescaler divides the selected clock by 1, 2, 4 or 8.
// - the oscillator enable bit turns the low-power oscillator on or off.
// - run bit 1 counts; run bit 0 stops and clears the gate toggle flop.
// - control bit 1 is unimplemented, reads zero and ignores writes.
// - the counter wraps FFFFh to 0000h and sets the overflow flag.
`timescale 1ns/1ps
module tcsc_top
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // external clock pins
    input  wire logic        external_count_pin,
    input  wire logic        crystal_clock,
    output logic             low_power_osc_enable,
    // gate toggle flop from gate logic
    input  wire logic        gate_toggle_event,
    output logic             gate_toggle,
    // interrupt
    output logic             irq
);
    // whole block state, registered as one word
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [15:0] count;
        logic        status;
        logic        mask;
        logic        toggle;
        logic [1:0]  div;
        logic [2:0]  ext_sync;
        logic [2:0]  xtal_sync;
        logic        raw_prev;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tcsc_state_t;

    // current and next state, prescaler link
    tcsc_state_t      state;
    tcsc_state_t      next_state;
    tcsc_prescale_if  ps ();

    // decoded controls, edge detects and bus qualifiers
    logic [1:0] src;
    logic       run;
    logic       sync_on;
    logic       ext_level;
    logic       ext_rise;
    logic       raw_level;
    logic       instr_tick;
    logic       do_write;
    logic       do_read;
    logic [31:0] wval;
    logic        wr_ok;
    logic        raw_rise;
    logic        sync_rise;
    logic [31:0] count_wr;

    // byte-lane merge of a write into a narrow register
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // known register decode
    function automatic logic mapped(input logic [7:0] a);
        return a == tcsc_pkg::ADDR_CTRL || a == tcsc_pkg::ADDR_COUNT ||
               a == tcsc_pkg::ADDR_STATUS || a == tcsc_pkg::ADDR_MASK ||
               a == tcsc_pkg::ADDR_GATE;
    endfunction : mapped

    // input prescaler on the selected tick
    tcsc_prescaler tcsc_prescaler_i
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ps      (ps.scaler)
    );

    // control field views
    assign src     = state.ctrl[tcsc_pkg::CS_LSB +: 2];
    assign run     = state.ctrl[tcsc_pkg::RUN_BIT];
    assign sync_on = !state.ctrl[tcsc_pkg::SYNC_BIT];
    assign low_power_osc_enable = state.ctrl[tcsc_pkg::OSC_BIT];

    // external source: crystal when oscillator enabled, else pin;
    // stage 1 is the first settled copy, stage 2 one clock older
    assign raw_level = state.ctrl[tcsc_pkg::OSC_BIT] ?
                       state.xtal_sync[1] : state.ext_sync[1];
    assign ext_level = state.ctrl[tcsc_pkg::OSC_BIT] ?
                       state.xtal_sync[2] : state.ext_sync[2];
    // bypass: edge between the two settled stages, one clock sooner
    assign raw_rise  = raw_level && !ext_level;
    // synchronised: older stage against its own history
    assign sync_rise = ext_level && !state.raw_prev;
    // sync disable picks the shorter path
    assign ext_rise  = sync_on ? sync_rise : raw_rise;
    // instruction clock: one tick in four system clocks
    assign instr_tick = state.div == tcsc_pkg::INSTR_DIV_LAST;

    // select source tick and feed prescaler
    always_comb
    begin
        case (src)
            tcsc_pkg::CS_INSTR: ps.tick_in = run && instr_tick;
            tcsc_pkg::CS_SYS:   ps.tick_in = run;
            tcsc_pkg::CS_EXT:   ps.tick_in = run && ext_rise;
            default:            ps.tick_in = 1'b0;
        endcase
    end
    // prescaler held clear while stopped, ratio from control
    assign ps.clear = !run;
    assign ps.ratio = state.ctrl[tcsc_pkg::PS_LSB +: 2];

    // write commit, read launch and lane-merged write values
    assign do_write = state.aw_got && state.w_got && !state.bvalid;
    assign do_read  = s_axi_arvalid && !state.rvalid;
    assign wval     = merge(32'h0000_0000, state.w_data, state.w_strb);
    assign count_wr = merge({16'h0000, state.count}, state.w_data,
                            state.w_strb);
    assign wr_ok    = mapped(state.aw_addr);

    // next state
    always_comb
    begin
        next_state = state;
        // free-running quarter-rate divider and pin samplers
        next_state.div = state.div + 2'h1;
        next_state.ext_sync = {state.ext_sync[1:0], external_count_pin};
        next_state.xtal_sync = {state.xtal_sync[1:0], crystal_clock};
        next_state.raw_prev = ext_level;
        // counter and overflow
        if (ps.tick_out)
        begin
            next_state.count = state.count + 16'h0001;
        end
        // gate toggle flop
        if (!run)
        begin
            next_state.toggle = 1'b0;
        end
        else if (gate_toggle_event)
        begin
            next_state.toggle = !state.toggle;
        end
        // write channel capture
        if (s_axi_awvalid && !state.aw_got)
        begin
            next_state.aw_got  = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state.w_got)
        begin
            next_state.w_got  = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end
        if (do_write)
        begin
            next_state.aw_got = 1'b0;
            next_state.w_got  = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp  = wr_ok ? tcsc_pkg::RESP_OKAY
                                      : tcsc_pkg::RESP_SLVERR;
            // register update on commit
            case (state.aw_addr)
                tcsc_pkg::ADDR_CTRL:
                begin
                    if (state.w_strb[0])
                    begin
                        next_state.ctrl = state.w_data[7:0]
                                          & tcsc_pkg::CTRL_WMASK;
                    end
                end
                tcsc_pkg::ADDR_COUNT:
                begin
                    next_state.count = count_wr[15:0];
                end
                tcsc_pkg::ADDR_MASK:
                begin
                    if (state.w_strb[0])
                    begin
                        next_state.mask = state.w_data[0];
                    end
                end
                default:
                begin
                    next_state.mask = state.mask;
                end
            endcase
        end
        // sticky overflow flag, set wins over write-one-clear
        if (do_write && state.aw_addr == tcsc_pkg::ADDR_STATUS
            && wval[0])
        begin
            next_state.status = 1'b0;
        end
        if (ps.tick_out && state.count == tcsc_pkg::COUNT_MAX)
        begin
            next_state.status = 1'b1;
        end
        // response taken by the master
        if (state.bvalid && s_axi_bready)
        begin
            next_state.bvalid = 1'b0;
        end
        // read channel
        if (do_read)
        begin
            next_state.rvalid = 1'b1;
            next_state.rresp  = mapped(s_axi_araddr) ? tcsc_pkg::RESP_OKAY
                                                     : tcsc_pkg::RESP_SLVERR;
            // read data for the addressed register
            case (s_axi_araddr)
                tcsc_pkg::ADDR_CTRL:
                    next_state.rdata = {24'h0, state.ctrl};
                tcsc_pkg::ADDR_COUNT:
                    next_state.rdata = {16'h0, state.count};
                tcsc_pkg::ADDR_STATUS:
                    next_state.rdata = {31'h0, state.status};
                tcsc_pkg::ADDR_MASK:
                    next_state.rdata = {31'h0, state.mask};
                tcsc_pkg::ADDR_GATE:
                    next_state.rdata = {31'h0, state.toggle};
                default:
                    next_state.rdata = 32'h0000_0000;
            endcase
        end
        else if (state.rvalid && s_axi_rready)
        begin
            next_state.rvalid = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            // all idle, control at its reset value
            state      <= '0;
            state.ctrl <= tcsc_pkg::CTRL_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    // bus handshakes and outputs
    assign s_axi_awready = !state.aw_got;
    assign s_axi_wready  = !state.w_got;
    assign s_axi_bvalid  = state.bvalid;
    assign s_axi_bresp   = state.bresp;
    assign s_axi_arready = !state.rvalid;
    assign s_axi_rvalid  = state.rvalid;
    assign s_axi_rdata   = state.rdata;
    assign s_axi_rresp   = state.rresp;
    assign gate_toggle   = state.toggle;
    assign irq           = state.status && state.mask;
endmodule : tcsc_top

// File: verification/tcsc_sva.sv
// port assertions for the timer clock control block
`timescale 1ns/1ps
module tcsc_sva
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // pins
    input wire logic        low_power_osc_enable,
    input wire logic        gate_toggle
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // captured addresses, write data and run bit
    logic [7:0]  wa;
    logic [7:0]  ra;
    logic [31:0] wd;
    logic        run;
    wire         bad_w = wa > tcsc_pkg::ADDR_GATE || wa[1:0] != 2'h0;
    wire         bad_r = ra > tcsc_pkg::ADDR_GATE || ra[1:0] != 2'h0;
    wire         ctl_b = s_axi_bvalid && s_axi_bready && wa == 8'h00;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wa <= 8'h00;
            ra <= 8'h00;
            wd <= 32'h0;
            run <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
            if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
            if (ctl_b) run <= wd[0];
        end
    end
    property p_osc; ctl_b |-> ##[0:1] low_power_osc_enable == wd[3];
    endproperty
    a_osc: assert property (p_osc) else $error("osc enable wrong");
    property p_gate; !run [*2] |-> !gate_toggle; endproperty
    a_gate: assert property (p_gate) else $error("gate not clear");
    property p_ctl_rd; s_axi_rvalid && ra == 8'h00 |->
        s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[1]; endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("ctrl bit 1");
    property p_bad_rd; s_axi_rvalid && bad_r |->
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0; endproperty
    a_bad_rd: assert property (p_bad_rd) else $error("bad read");
    property p_bad_wr; s_axi_bvalid && bad_w |-> s_axi_bresp == 2'h2;
    endproperty
    a_bad_wr: assert property (p_bad_wr) else $error("bad write");
    property p_r_next; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_next: assert property (p_r_next) else $error("no rvalid");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
    property p_b_time; s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
    a_b_time: assert property (p_b_time) else $error("no bvalid");
    // main scenarios seen
    c_osc: cover property (ctl_b && wd[3]);
    c_bad: cover property (s_axi_rvalid && bad_r);
    c_gate: cover property ($fell(gate_toggle));
endmodule : tcsc_sva

bind tcsc_top tcsc_sva tcsc_sva_i (.clk_sys, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .low_power_osc_enable,
    .gate_toggle);

// File: verification/tcsc_ext_clock_model.sv
// behavioural count pin and crystal driving the timer
`timescale 1ns/1ps
module tcsc_ext_clock_model
(
    // controls
    input  wire logic run,
    input  wire logic osc_enable,
    // clocks and edge counts
    output logic      external_count_pin,
    output logic      crystal_clock,
    output int        pin_edges,
    output int        xtal_edges
);
    // idle low before any burst
    initial
    begin
        external_count_pin = 1'b0;
        crystal_clock = 1'b0;
        pin_edges = 0;
        xtal_edges = 0;
    end
    // pin clock stands low outside bursts
    always #37 external_count_pin = run ? !external_count_pin : 1'b0;
    // crystal swings only while its oscillator is enabled
    always #53 crystal_clock = run && osc_enable ? !crystal_clock : 1'b0;
    // rising edges handed over
    always @(posedge external_count_pin) pin_edges++;
    always @(posedge crystal_clock) xtal_edges++;
endmodule : tcsc_ext_clock_model

// File: verification/tcsc_top_test.sv
// self-checking bench for the timer clock control block
`timescale 1ns/1ps
module tcsc_top_test;
    logic        clk_sys, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, pin_run;
    logic        external_count_pin, crystal_clock, low_power_osc_enable;
    logic        gate_toggle_event, gate_toggle;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          pin_edges, xtal_edges, bad_count, tests_run, cycles;
    tcsc_top tcsc_top_i (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_count_pin,
        .crystal_clock, .low_power_osc_enable, .gate_toggle_event,
        .gate_toggle, .irq);
    tcsc_ext_clock_model tcsc_ext_clock_model_i (.run(pin_run),
        .osc_enable(low_power_osc_enable), .external_count_pin,
        .crystal_clock, .pin_edges, .xtal_edges);
    // compare with tolerance, unknown never matches
    task automatic check(input string nm, input logic [31:0] e, g,
                         input int t);
        tests_run++;
        if (^g === 1'bx || g > e + t || g + t < e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask : check
    // bus write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = 2'h0);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever
        begin
            @(posedge clk_sys);
            if (s_axi_bvalid === 1'b1) break;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        check("bresp", er, s_axi_bresp, 0);
    endtask : wr
    // bus read compared with expectation, rready raised once rvalid shows
    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] ed, input int t = 0,
                      input logic [1:0] er = 2'h0);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check(nm, ed, s_axi_rdata, t);
        check("rresp", er, s_axi_rresp, 0);
    endtask : rd
    // one-cycle gate event, then pin check
    task automatic gate(input logic e);
        gate_toggle_event <= 1'b1;
        @(posedge clk_sys);
        gate_toggle_event <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("gate_toggle", e, gate_toggle, 0);
    endtask : gate
    task automatic see_irq(input logic e);
        @(posedge clk_sys);
        check("irq", e, irq, 0);
    endtask : see_irq
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = !clk_sys;
    end
    // hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            bad_count++;
            end_of_test();
        end
    end
    // test sequence
    initial
    begin
        int e0;
        int x0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, pin_run} = 4'h0;
        {gate_toggle_event, s_axi_awaddr, s_axi_araddr} = 17'h0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb, s_axi_wdata} = 38'h0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h2F;
        rst = 1'b1;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd("ctrl", 8'h00, 32'h0);
        rd("count", 8'h04, 32'h0);
        rd("status", 8'h08, 32'h0);
        rd("mask", 8'h0C, 32'h0);
        wr(8'h00, 32'hFF);
        rd("ctrl", 8'h00, 32'hFD);
        check("osc", 1'b1, low_power_osc_enable, 0);
        wr(8'h00, 32'h0);
        check("osc", 1'b0, low_power_osc_enable, 0);
        wr(8'h14, 32'h1, 2'h2);
        rd("unmapped", 8'h14, 32'h0, 0, 2'h2);
        $display("test registers done");
        for (int s = 0; s < 4; s++)
            for (int p = 0; p < 4; p++)
            begin
                if (s == 2) continue;
                wr(8'h04, 32'h0);
                wr(8'h00, {s[1:0], p[1:0], 4'h1});
                repeat (400) @(posedge clk_sys);
                wr(8'h00, 32'h0);
                e0 = s == 3 ? 0 : 403 / ((s == 0 ? 4 : 1) << p);
                rd("count", 8'h04, e0, 3);
            end
        $display("test sources done");
        for (int k = 0; k < 3; k++)
        begin
            wr(8'h04, 32'h0);
            wr(8'h00, 8'h81 | (k > 0 ? 8'h04 : 8'h00)
                | (k == 2 ? 8'h08 : 8'h00));
            e0 = pin_edges;
            x0 = xtal_edges;
            pin_run <= 1'b1;
            repeat (300) @(posedge clk_sys);
            pin_run <= 1'b0;
            repeat (10) @(posedge clk_sys);
            wr(8'h00, 32'h0);
            e0 = k == 2 ? xtal_edges - x0 : pin_edges - e0;
            rd("ext count", 8'h04, e0);
        end
        $display("test external done");
        wr(8'h0C, 32'h1);
        wr(8'h04, 32'hFFFD);
        wr(8'h00, 32'h41);
        repeat (10) @(posedge clk_sys);
        wr(8'h00, 32'h0);
        rd("count", 8'h04, 32'hA, 3);
        rd("status", 8'h08, 32'h1);
        see_irq(1'b1);
        wr(8'h0C, 32'h0);
        see_irq(1'b0);
        wr(8'h0C, 32'h1);
        see_irq(1'b1);
        wr(8'h08, 32'h1);
        rd("status", 8'h08, 32'h0);
        see_irq(1'b0);
        $display("test overflow done");
        wr(8'h00, 32'h01);
        gate(1'b1);
        rd("gate", 8'h10, 32'h1);
        wr(8'h00, 32'h0);
        gate(1'b0);
        rd("gate", 8'h10, 32'h0);
        $display("test gate done");
        end_of_test();
    end
endmodule : tcsc_top_test
